/* sim/cies_ctl_model.sv */
// Interrupt controller stand-in plus the system stack memory, written on the clock and read combinationally.
// Assumes the bench raises one request at a time and holds level and bank.
module cies_ctl_model (
  input  wire logic        ref_clk,
  input  wire logic        raise,
  input  wire logic        irq_ack,
  output wire logic        irq_req,
  input  wire logic        stk_we,
  input  wire logic [15:0] stk_addr,
  input  wire logic [15:0] stk_wdata,
  output wire logic [15:0] stk_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:65535];
  logic        held_r = 1'b0;
  // Raised while the bench holds raise; dropped once served so it is not taken twice
  // Stack read is combinational on the registered address the unit presents
  assign stk_rdata = mem[stk_addr];
  assign irq_req = raise && !held_r && !irq_ack;
  always @(posedge ref_clk) begin
    if (irq_ack) begin
      held_r <= 1'b1;
    end else if (!raise) begin
      held_r <= 1'b0;
    end
    if (stk_we) begin
      mem[stk_addr] <= stk_wdata;
    end
  end
endmodule

/* sim/cies_top_asserts.sv */
// Port checker for the interrupt entry unit.
// Assumes a bind onto cies_top; one clock, async reset.
module cies_top_asserts (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        irq_req,
  input wire logic [3:0]  irq_level,
  input wire logic        irq_ack,
  input wire logic        pet_ack,
  input wire logic        fetch_start,
  input wire logic        stk_we,
  input wire logic [15:0] stk_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  property p_bus; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_bus: assert property (p_bus) else $error("bus not answered");
  property p_low; irq_req && irq_level == 4'h0 |=> !irq_ack; endproperty
  a_low: assert property (p_low) else $error("level zero taken");
  property p_cause; irq_ack |-> $past(irq_req); endproperty
  a_cause: assert property (p_cause) else $error("ack without request");
  property p_pulse; irq_ack |=> !irq_ack; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_push; irq_ack |=> stk_we; endproperty
  a_push: assert property (p_push) else $error("no status push");
  property p_fetch; irq_ack |-> ##[3:4] fetch_start; endproperty
  a_fetch: assert property (p_fetch) else $error("no routine fetch");
  property p_desc; stk_we && $past(stk_we) |-> stk_addr == $past(stk_addr) - 16'h0002; endproperty
  a_desc: assert property (p_desc) else $error("push order wrong");
  property p_excl; !(irq_ack && pet_ack); endproperty
  a_excl: assert property (p_excl) else $error("transfer during entry");
  c_entry: cover property (irq_ack ##1 stk_we ##1 stk_we);
  c_pet: cover property (pet_ack);
  c_fetch: cover property (fetch_start);
endmodule

/* sim/cies_top_test.sv */
// Bench for the interrupt entry unit: bus tasks and directed tests.
// Assumes the controller model supplies requests and the stack memory.
`include "cies_defs.vh"
module cies_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, raise = 0, pet = 0;
  logic [3:0]  sel = 4'hF, lvl = 4'h0;
  logic [1:0]  bnk = 2'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rd, dat_o;
  logic        ack, irq_req, irq_ack, pet_ack, fetch, stk_we;
  logic [15:0] stk_addr, stk_wdata, stk_rdata;
  int          error_cnt = 0, checks = 0, acks = 0, pets = 0;
  cies_top dut_u (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .irq_req(irq_req), .irq_level(lvl), .irq_bank(bnk), .irq_vec_ip(16'h4440),
    .irq_vec_csp(8'h00), .pet_req(pet), .irq_ack(irq_ack), .pet_ack(pet_ack),
    .fetch_start(fetch), .stk_we(stk_we), .stk_addr(stk_addr), .stk_wdata(stk_wdata),
    .stk_rdata(stk_rdata));
  cies_ctl_model ctl_u (.ref_clk(ref_clk), .raise(raise), .irq_ack(irq_ack),
    .irq_req(irq_req), .stk_we(stk_we), .stk_addr(stk_addr), .stk_wdata(stk_wdata),
    .stk_rdata(stk_rdata));
  always @(posedge ref_clk) begin
    if (!rst) begin
      acks <= acks + irq_ack;
      pets <= pets + pet_ack;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge ref_clk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    wb(0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Commands are dropped while busy, so wait for the idle state after each
  task automatic cmd(input logic [31:0] d);
    wb(1, `CIES_OFS_CMD, d);
    repeat (40) begin
      wb(0, `CIES_OFS_STAT, 32'h0);
      if (rd[2:0] === 3'h0) break;
    end
  endtask
  task automatic req(input logic [3:0] l, input logic [1:0] b, input int n);
    lvl <= l;
    bnk <= b;
    raise <= 1;
    repeat (12) @(posedge ref_clk);
    raise <= 0;
    chk(acks, n);
  endtask
  task automatic pulse;
    pet <= 1;
    @(posedge ref_clk);
    pet <= 0;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial forever #2.5 ref_clk = ~ref_clk;
  initial begin
    #50us;
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 0;
    rc(`CIES_OFS_PSW, 32'h0);
    wb(1, `CIES_OFS_IP, 32'h1110);
    wb(1, `CIES_OFS_PSW, 32'h0800);
    rc(`CIES_OFS_PSW, 32'h0800);
    req(4'h0, 2'h2, 0);
    req(4'h3, 2'h2, 1);
    rc(`CIES_OFS_PSW, 32'h3A00);
    rc(`CIES_OFS_IP, 32'h4440);
    rc(`CIES_OFS_CP, 32'h0);
    chk(ctl_u.mem[16'hFBFE], 32'h0800);
    chk(ctl_u.mem[16'hFBFC], 32'h1110);
    cmd(32'h1);
    rc(`CIES_OFS_PSW, 32'h0800);
    rc(`CIES_OFS_IP, 32'h1110);
    $display("test irq done");
    wb(1, `CIES_OFS_PSW, 32'h0A00);
    cmd(32'h20000003);
    rc(`CIES_OFS_PSW, 32'hF800);
    req(4'hE, 2'h1, 1);
    cmd(32'h1);
    $display("test hw trap done");
    wb(1, `CIES_OFS_PSW, 32'h0200);
    cmd(32'h30000002);
    rc(`CIES_OFS_PSW, 32'h0200);
    rc(`CIES_OFS_IP, 32'h3000);
    req(4'h5, 2'h1, 1);
    pulse();
    chk(pets, 0);
    cmd(32'h1);
    wb(1, `CIES_OFS_PSW, 32'h5800);
    pulse();
    chk(pets, 1);
    rc(`CIES_OFS_PSW, 32'h5800);
    $display("test sw trap done");
    cmd(32'h12340004);
    rc(`CIES_OFS_CP, 32'h1234);
    chk(ctl_u.mem[16'hFBFE], 32'h0);
    $display("test context done");
    wb(1, `CIES_OFS_CTRL, 32'h0);
    wb(1, `CIES_OFS_CSP, 32'h12);
    req(4'h6, 2'h3, 2);
    rc(`CIES_OFS_PSW, 32'h6B00);
    rc(`CIES_OFS_CSP, 32'h0);
    chk(ctl_u.mem[16'hFBFC], 32'h5800);
    chk(ctl_u.mem[16'hFBFA], 32'h0012);
    cmd(32'h1);
    rc(`CIES_OFS_CSP, 32'h12);
    rc(`CIES_OFS_PSW, 32'h5800);
    cmd(32'h5);
    rc(`CIES_OFS_CP, 32'h0);
    $display("test segmented done");
    complete_run();
  end
endmodule
bind cies_top cies_top_asserts chk_u (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .irq_req(irq_req), .irq_level(irq_level),
  .irq_ack(irq_ack), .pet_ack(pet_ack), .fetch_start(fetch_start), .stk_we(stk_we),
  .stk_addr(stk_addr));

/* verilog/cies_defs.vh */
// Constants for the interrupt entry and status unit: register map, fields, codes.
// Assumes a 32-bit classic Wishbone bus with word-aligned registers.
`ifndef CIES_DEFS_VH
`define CIES_DEFS_VH
`define CIES_OFS_PSW      8'h00
`define CIES_OFS_CTRL     8'h04
`define CIES_OFS_IP       8'h08
`define CIES_OFS_CSP      8'h0C
`define CIES_OFS_CP       8'h10
`define CIES_OFS_CMD      8'h14
`define CIES_OFS_SP       8'h18
`define CIES_OFS_STAT     8'h1C
`define CIES_PSW_RST      16'h0000
`define CIES_LVL_HI       15
`define CIES_LVL_LO       12
`define CIES_GATE_BIT     11
`define CIES_BANK_HI      9
`define CIES_BANK_LO      8
`define CIES_LVL_MAX      4'hF
`define CIES_BANK_GLOBAL  2'h0
`define CIES_SP_RST       16'hFC00
`define CIES_CMD_RETURN_FROM_INTERRUPT_INSTR     3'h1
`define CIES_CMD_SWTRAP   3'h2
`define CIES_CMD_HWTRAP   3'h3
`define CIES_CMD_SWITCH_CONTEXT_INSTR     3'h4
`define CIES_CMD_POPCP    3'h5
`define CIES_CMD_TRAPVEC  12
`define CIES_WORD_STEP    16'h0002
`endif

/* verilog/cies_top.v */
// Interrupt entry, status word, trap and context control of a 16-bit CPU core.
// Assumes an interrupt controller on the same clock and a Wishbone master for software.
//
// The address map and the Wishbone interface to the registers are this design's own decisions.
`include "cies_defs.vh"
module cies_top (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        irq_req,
  input  wire [3:0]  irq_level,
  input  wire [1:0]  irq_bank,
  input  wire [15:0] irq_vec_ip,
  input  wire [7:0]  irq_vec_csp,
  input  wire        pet_req,
  output reg         irq_ack,
  output reg         pet_ack,
  output reg         fetch_start,
  output reg         stk_we,
  output reg  [15:0] stk_addr,
  output reg  [15:0] stk_wdata,
  input  wire [15:0] stk_rdata
);
  localparam ST_IDLE = 3'd0;
  localparam ST_PUSH = 3'd1;
  localparam ST_POP  = 3'd2;
  localparam ST_LOAD = 3'd3;

  reg  [15:0] psw_r;
  reg  [15:0] ip_r;
  reg  [7:0]  csp_r;
  reg  [15:0] cp_r;
  reg  [15:0] sp_r;
  reg         seg_dis_r;
  reg  [2:0]  st_r;
  reg  [1:0]  step_r;
  reg  [2:0]  op_r;
  reg  [15:0] sv_psw_r;
  reg  [15:0] new_psw_r;
  reg  [15:0] vec_ip_r;
  reg  [7:0]  vec_csp_r;
  reg  [15:0] imm_r;
  wire [15:0] st_w;
  wire        wb_hit;
  wire        wr;
  wire        busy;
  wire        take_irq;
  wire        take_pet;
  wire [1:0]  last_push;
  wire [1:0]  last_pop;

  assign wb_hit    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr        = wb_hit & wb_we_i & wb_sel_i[0] & wb_sel_i[1];
  assign busy      = (st_r != ST_IDLE);
  // Strict compare and global gate; controller already filters per source
  assign take_irq  = ~busy & irq_req & psw_r[`CIES_GATE_BIT] &
                     (irq_level > psw_r[`CIES_LVL_HI:`CIES_LVL_LO]);
  assign take_pet  = ~busy & ~take_irq & pet_req & psw_r[`CIES_GATE_BIT] &
                     (psw_r[`CIES_LVL_HI:`CIES_LVL_LO] != `CIES_LVL_MAX);
  assign last_push = seg_dis_r ? 2'd1 : 2'd2;
  assign last_pop  = seg_dis_r ? 2'd1 : 2'd2;
  assign st_w      = {12'h000, seg_dis_r, st_r};

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      psw_r       <= `CIES_PSW_RST;
      ip_r        <= 16'h0000;
      csp_r       <= 8'h00;
      cp_r        <= 16'h0000;
      sp_r        <= `CIES_SP_RST;
      seg_dis_r   <= 1'b1;
      st_r        <= ST_IDLE;
      step_r      <= 2'd0;
      op_r        <= 3'd0;
      sv_psw_r    <= 16'h0000;
      new_psw_r   <= 16'h0000;
      vec_ip_r    <= 16'h0000;
      vec_csp_r   <= 8'h00;
      imm_r       <= 16'h0000;
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h00000000;
      irq_ack     <= 1'b0;
      pet_ack     <= 1'b0;
      fetch_start <= 1'b0;
      stk_we      <= 1'b0;
      stk_addr    <= 16'h0000;
      stk_wdata   <= 16'h0000;
    end else begin
      wb_ack_o    <= wb_hit;
      irq_ack     <= 1'b0;
      pet_ack     <= 1'b0;
      fetch_start <= 1'b0;
      stk_we      <= 1'b0;
      if (wb_hit & ~wb_we_i) begin
        case (wb_adr_i)
          `CIES_OFS_PSW:  wb_dat_o <= {16'h0000, psw_r};
          `CIES_OFS_CTRL: wb_dat_o <= {31'h00000000, seg_dis_r};
          `CIES_OFS_IP:   wb_dat_o <= {16'h0000, ip_r};
          `CIES_OFS_CSP:  wb_dat_o <= {24'h000000, csp_r};
          `CIES_OFS_CP:   wb_dat_o <= {16'h0000, cp_r};
          `CIES_OFS_SP:   wb_dat_o <= {16'h0000, sp_r};
          `CIES_OFS_STAT: wb_dat_o <= {16'h0000, st_w};
          default:        wb_dat_o <= 32'h00000000;
        endcase
      end
      // Pet transfer only steals cycles; status untouched
      if (take_pet)
        pet_ack <= 1'b1;
      case (st_r)
        ST_IDLE: begin
          if (take_irq) begin
            irq_ack   <= 1'b1;
            sv_psw_r  <= psw_r;
            new_psw_r <= {irq_level, psw_r[11:10], irq_bank, psw_r[7:0]};
            vec_ip_r  <= irq_vec_ip;
            vec_csp_r <= irq_vec_csp;
            step_r    <= 2'd0;
            st_r      <= ST_PUSH;
          end else if (wr & (wb_adr_i == `CIES_OFS_CMD)) begin
            op_r   <= wb_dat_i[2:0];
            imm_r  <= wb_dat_i[31:16];
            step_r <= 2'd0;
            case (wb_dat_i[2:0])
              `CIES_CMD_RETURN_FROM_INTERRUPT_INSTR: st_r <= ST_POP;
              `CIES_CMD_POPCP: st_r <= ST_POP;
              `CIES_CMD_SWITCH_CONTEXT_INSTR: st_r <= ST_PUSH;
              `CIES_CMD_SWTRAP: begin
                sv_psw_r  <= psw_r;
                new_psw_r <= psw_r;
                vec_ip_r  <= wb_dat_i[31:16];
                vec_csp_r <= csp_r;
                st_r      <= ST_PUSH;
              end
              `CIES_CMD_HWTRAP: begin
                sv_psw_r  <= psw_r;
                new_psw_r <= {`CIES_LVL_MAX, psw_r[11:10], `CIES_BANK_GLOBAL,
                              psw_r[7:0]};
                vec_ip_r  <= wb_dat_i[31:16];
                vec_csp_r <= 8'h00;
                st_r      <= ST_PUSH;
              end
              default: st_r <= ST_IDLE;
            endcase
          end else if (wr) begin
            case (wb_adr_i)
              `CIES_OFS_PSW:  psw_r <= wb_dat_i[15:0];
              `CIES_OFS_CTRL: seg_dis_r <= wb_dat_i[0];
              `CIES_OFS_IP:   ip_r <= wb_dat_i[15:0];
              `CIES_OFS_CSP:  csp_r <= wb_dat_i[7:0];
              `CIES_OFS_SP:   sp_r <= wb_dat_i[15:0];
              default:        psw_r <= psw_r;
            endcase
          end
        end
        ST_PUSH: begin
          // Stack grows down; one word per cycle
          stk_we   <= 1'b1;
          stk_addr <= sp_r - `CIES_WORD_STEP;
          sp_r     <= sp_r - `CIES_WORD_STEP;
          step_r   <= step_r + 2'd1;
          if (op_r == `CIES_CMD_SWITCH_CONTEXT_INSTR) begin
            stk_wdata <= cp_r;
            cp_r      <= imm_r;
            op_r      <= 3'd0;
            st_r      <= ST_IDLE;
          end else begin
            if (step_r == 2'd0)
              stk_wdata <= sv_psw_r;
            else if ((step_r == 2'd1) & ~seg_dis_r)
              stk_wdata <= {8'h00, csp_r};
            else
              stk_wdata <= ip_r;
            if (step_r == last_push)
              st_r <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          // Only status, pointers change; data page and context kept
          psw_r       <= new_psw_r;
          ip_r        <= vec_ip_r;
          csp_r       <= vec_csp_r;
          fetch_start <= 1'b1;
          op_r        <= 3'd0;
          st_r        <= ST_IDLE;
        end
        ST_POP: begin
          // Address leads by one step: the word at the previous address is read now
          stk_addr <= sp_r;
          step_r   <= step_r + 2'd1;
          if (op_r == `CIES_CMD_POPCP) begin
            if (step_r == 2'd0) begin
              sp_r <= sp_r + `CIES_WORD_STEP;
            end else begin
              cp_r <= stk_rdata;
              op_r <= 3'd0;
              st_r <= ST_IDLE;
            end
          end else begin
            if (step_r <= last_pop)
              sp_r <= sp_r + `CIES_WORD_STEP;
            if (step_r == 2'd1)
              ip_r <= stk_rdata;
            else if ((step_r == 2'd2) & ~seg_dis_r)
              csp_r <= stk_rdata[7:0];
            if (step_r == (last_pop + 2'd1)) begin
              psw_r <= stk_rdata;
              op_r  <= 3'd0;
              st_r  <= ST_IDLE;
            end
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
  // Register sets live outside; this unit only selects them, so local sets persist.
endmodule
